// ### src/ilrs_pkg.sv
// constants, types and helpers for the inter-level register and skip executor
// Operation
// - Sixteen independent register and status sets are kept, one per program level.
// - Instruction bits 0-2 select the register, coded as register-operation destinations.
// - Instruction bits 3-6 select the target level, and the current level may be chosen too.
// - An inter-level read copies the selected register of that level into the current A.
// - A read with selector zero puts status in A bits 1-7 and clears A bit 0 and bits 8-15.
// - The inter-level read is privileged and runs only where such instructions are allowed.
// - An inter-level write copies the current A into the selected register of any level.
// - A write aimed at the program counter of the current level does nothing.
// - A write with selector zero loads A bits 1-7 into the status of the selected level.
// - The inter-level write is privileged and runs only where such instructions are allowed.
// - Code 000 needs zero set, 100 zero clear; others test sign, sign xor overflow, carry.
package ilrs_pkg;
  localparam int ILRS_WORD_W = 16;
  localparam int ILRS_LEVEL_W = 4;
  localparam int ILRS_SEL_W = 3;
  localparam int ILRS_IDX_W = ILRS_LEVEL_W + ILRS_SEL_W;
  localparam int ILRS_DEPTH = 1 << ILRS_IDX_W;
  // field positions inside the instruction word
  localparam int ILRS_SEL_LSB = 0;
  localparam int ILRS_LVL_LSB = 3;
  localparam int ILRS_SRC_LSB = 3;
  localparam int ILRS_COND_LSB = 8;
  localparam int ILRS_GRP_LSB = 6;
  localparam int ILRS_GRP_W = 2;
  // opcode patterns
  localparam logic [15:0] ILRS_RW_MASK = 16'hff80;
  localparam logic [15:0] ILRS_OP_READ = 16'hd780;
  localparam logic [15:0] ILRS_OP_WRITE = 16'hd700;
  localparam logic [15:0] ILRS_SKIP_MASK = 16'hf800;
  localparam logic [15:0] ILRS_OP_SKIP = 16'hc000;
  localparam logic [1:0] ILRS_GRP_SKIP = 2'h0;
  // register selector codes
  localparam logic [2:0] ILRS_SEL_STATUS = 3'h0;
  localparam logic [2:0] ILRS_SEL_P = 3'h2;
  localparam logic [2:0] ILRS_SEL_A = 3'h5;
  // status occupies bits 1-7 of a word
  localparam logic [15:0] ILRS_STS_MASK = 16'h00fe;
  localparam logic [15:0] ILRS_ONE = 16'h0001;
  localparam logic [15:0] ILRS_ZERO = 16'h0000;
  // skip conditions
  localparam logic [2:0] ILRS_C_EQ = 3'h0;
  localparam logic [2:0] ILRS_C_SIGN_CLR = 3'h1;
  localparam logic [2:0] ILRS_C_SGE = 3'h2;
  localparam logic [2:0] ILRS_C_UGE = 3'h3;
  localparam logic [2:0] ILRS_C_NE = 3'h4;
  localparam logic [2:0] ILRS_C_SIGN_SET = 3'h5;
  localparam logic [2:0] ILRS_C_SLT = 3'h6;
  localparam logic [2:0] ILRS_C_ULT = 3'h7;

  typedef enum logic [1:0] {st_idle, st_exec, st_bump} ilrs_state_t;

  // one flat index per level and register
  function automatic logic [ILRS_IDX_W-1:0] ilrs_idx(input logic [3:0] lvl, input logic [2:0] sel);
    ilrs_idx = {lvl, sel};
  endfunction

  function automatic logic ilrs_is_read(input logic [15:0] w);
    ilrs_is_read = (w & ILRS_RW_MASK) == ILRS_OP_READ;
  endfunction

  function automatic logic ilrs_is_write(input logic [15:0] w);
    ilrs_is_write = (w & ILRS_RW_MASK) == ILRS_OP_WRITE;
  endfunction

  function automatic logic ilrs_is_skipgrp(input logic [15:0] w);
    ilrs_is_skipgrp = (w & ILRS_SKIP_MASK) == ILRS_OP_SKIP;
  endfunction

  function automatic logic ilrs_cond(input logic [2:0] cd, input logic s, input logic z,
                                     input logic c, input logic o);
    unique case (cd)
      ILRS_C_EQ: ilrs_cond = z;
      ILRS_C_SIGN_CLR: ilrs_cond = !s;
      ILRS_C_SGE: ilrs_cond = !(s ^ o);
      ILRS_C_UGE: ilrs_cond = c;
      ILRS_C_NE: ilrs_cond = !z;
      ILRS_C_SIGN_SET: ilrs_cond = s;
      ILRS_C_SLT: ilrs_cond = s ^ o;
      ILRS_C_ULT: ilrs_cond = !c;
    endcase
  endfunction
endpackage

// ### src/ilrs_regfile.sv
// per-level register file with one write port and two registered read ports
`timescale 1ns/1ps
module ilrs_regfile
  import ilrs_pkg::*;
#(
  parameter int WIDTH = ILRS_WORD_W,
  parameter int DEPTH = ILRS_DEPTH,
  parameter int AW = ILRS_IDX_W
) (
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  // read ports
  input wire logic [AW-1:0] raddr_a,
  input wire logic [AW-1:0] raddr_b,
  output logic [WIDTH-1:0] rdata_a,
  output logic [WIDTH-1:0] rdata_b
);
  // contents are not reset; only the read registers are
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clock) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    if (!resetn) begin
      rdata_a <= '0;
      rdata_b <= '0;
    end else begin
      rdata_a <= mem[raddr_a];
      rdata_b <= mem[raddr_b];
    end
  end
endmodule // ilrs_regfile

// ### src/ilrs_core.sv
// executor for inter-level register read/write and conditional skip
`timescale 1ns/1ps
module ilrs_core
  import ilrs_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic resetn,
  // instruction hand-off
  input wire logic [15:0] instr,
  input wire logic instr_valid,
  input wire logic [3:0] current_level,
  input wire logic priv_allowed,
  output logic ready,
  // completion
  output logic done,
  output logic priv_violation,
  output logic skip_taken,
  output logic extended_group,
  // indicators of the last skip compare
  output logic flag_s,
  output logic flag_z,
  output logic flag_c,
  output logic flag_o,
  // outside access to the register sets; writes land only while idle
  input wire logic host_we,
  input wire logic [3:0] host_level,
  input wire logic [2:0] host_sel,
  input wire logic [15:0] host_wdata,
  input wire logic [3:0] host_rd_level,
  input wire logic [2:0] host_rd_sel,
  output logic [15:0] host_rdata
);
  ilrs_state_t state, next_state;
  logic [15:0] ir, next_ir;
  logic [3:0] cur, next_cur;
  logic next_done, next_priv_violation, next_skip_taken, next_extended_group;
  logic next_flag_s, next_flag_z, next_flag_c, next_flag_o;
  logic mem_we;
  logic [ILRS_IDX_W-1:0] mem_waddr, raddr_a, raddr_b;
  logic [15:0] mem_wdata, rdata_a, rdata_b;
  logic [2:0] ir_sel, ir_src, ir_cond;
  logic [3:0] ir_lvl;
  logic [15:0] opd_d, opd_s, alu_res;
  logic [16:0] alu_sum;
  logic alu_s, alu_z, alu_c, alu_o, cond_hit, own_pc, in_rw;

  // one register set per level, addressed by level and selector
  ilrs_regfile u_regs (
    .clock(clock),
    .resetn(resetn),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr_a(raddr_a),
    .raddr_b(raddr_b),
    .rdata_a(rdata_a),
    .rdata_b(rdata_b)
  );

  assign host_rdata = rdata_b;
  assign ready = state == st_idle;
  assign in_rw = ilrs_is_read(instr) || ilrs_is_write(instr);

  assign ir_sel = ir[ILRS_SEL_LSB +: ILRS_SEL_W];
  assign ir_lvl = ir[ILRS_LVL_LSB +: ILRS_LEVEL_W];
  assign ir_src = ir[ILRS_SRC_LSB +: ILRS_SEL_W];
  assign ir_cond = ir[ILRS_COND_LSB +: ILRS_SEL_W];
  assign own_pc = (ir_lvl == cur) && (ir_sel == ILRS_SEL_P);

  // selector zero names no register in a compare, so it reads as zero
  assign opd_d = (ir_sel == ILRS_SEL_STATUS) ? ILRS_ZERO : rdata_a;
  assign opd_s = (ir_src == ILRS_SEL_STATUS) ? ILRS_ZERO : rdata_b;
  assign alu_sum = {1'b0, opd_d} + {1'b0, ~opd_s} + {1'b0, ILRS_ONE};
  assign alu_res = alu_sum[15:0];
  assign alu_s = alu_res[15];
  assign alu_z = alu_res == ILRS_ZERO;
  assign alu_c = alu_sum[16];
  assign alu_o = (opd_d[15] != opd_s[15]) && (alu_res[15] != opd_d[15]);
  assign cond_hit = ilrs_cond(ir_cond, alu_s, alu_z, alu_c, alu_o);

  always_comb begin
    next_state = state;
    next_ir = ir;
    next_cur = cur;
    next_done = 1'b0;
    next_priv_violation = 1'b0;
    next_skip_taken = 1'b0;
    next_extended_group = 1'b0;
    next_flag_s = flag_s;
    next_flag_z = flag_z;
    next_flag_c = flag_c;
    next_flag_o = flag_o;
    // outside writes only land while idle, when the executor never writes
    mem_we = host_we;
    mem_waddr = ilrs_idx(host_level, host_sel);
    mem_wdata = host_wdata;
    raddr_a = ilrs_idx(current_level, ILRS_SEL_A);
    raddr_b = ilrs_idx(host_rd_level, host_rd_sel);
    unique case (state)
      st_idle: begin
        if (instr_valid) begin
          next_ir = instr;
          next_cur = current_level;
          if (in_rw && !priv_allowed) begin
            next_priv_violation = 1'b1;
            next_done = 1'b1;
          end else if (ilrs_is_read(instr)) begin
            raddr_a = ilrs_idx(instr[ILRS_LVL_LSB +: ILRS_LEVEL_W],
                               instr[ILRS_SEL_LSB +: ILRS_SEL_W]);
            next_state = st_exec;
          end else if (ilrs_is_write(instr)) begin
            next_state = st_exec;
          end else if (ilrs_is_skipgrp(instr) &&
                       instr[ILRS_GRP_LSB +: ILRS_GRP_W] == ILRS_GRP_SKIP) begin
            raddr_a = ilrs_idx(current_level, instr[ILRS_SEL_LSB +: ILRS_SEL_W]);
            raddr_b = ilrs_idx(current_level, instr[ILRS_SRC_LSB +: ILRS_SEL_W]);
            next_state = st_exec;
          end else begin
            // extended group and anything else is left to other decoders
            next_extended_group = 1'b1;
            next_done = 1'b1;
          end
        end
      end
      st_exec: begin
        mem_we = 1'b0;
        if (ilrs_is_read(ir)) begin
          mem_we = 1'b1;
          mem_waddr = ilrs_idx(cur, ILRS_SEL_A);
          mem_wdata = (ir_sel == ILRS_SEL_STATUS) ? (rdata_a & ILRS_STS_MASK) : rdata_a;
          next_done = 1'b1;
          next_state = st_idle;
        end else if (ilrs_is_write(ir)) begin
          mem_we = !own_pc;
          mem_waddr = ilrs_idx(ir_lvl, ir_sel);
          mem_wdata = (ir_sel == ILRS_SEL_STATUS) ? (rdata_a & ILRS_STS_MASK) : rdata_a;
          next_done = 1'b1;
          next_state = st_idle;
        end else begin
          next_flag_s = alu_s;
          next_flag_z = alu_z;
          next_flag_c = alu_c;
          next_flag_o = alu_o;
          if (cond_hit) begin
            raddr_a = ilrs_idx(cur, ILRS_SEL_P);
            next_state = st_bump;
          end else begin
            next_done = 1'b1;
            next_state = st_idle;
          end
        end
      end
      st_bump: begin
        // the counter already points past the skip, one more step skips the next word
        mem_we = 1'b1;
        mem_waddr = ilrs_idx(cur, ILRS_SEL_P);
        mem_wdata = rdata_a + ILRS_ONE;
        next_skip_taken = 1'b1;
        next_done = 1'b1;
        next_state = st_idle;
      end
      default: begin
        mem_we = 1'b0;
        next_state = st_idle;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!resetn) begin
      state <= st_idle;
      ir <= ILRS_ZERO;
      cur <= '0;
      done <= 1'b0;
      priv_violation <= 1'b0;
      skip_taken <= 1'b0;
      extended_group <= 1'b0;
      flag_s <= 1'b0;
      flag_z <= 1'b0;
      flag_c <= 1'b0;
      flag_o <= 1'b0;
    end else begin
      state <= next_state;
      ir <= next_ir;
      cur <= next_cur;
      done <= next_done;
      priv_violation <= next_priv_violation;
      skip_taken <= next_skip_taken;
      extended_group <= next_extended_group;
      flag_s <= next_flag_s;
      flag_z <= next_flag_z;
      flag_c <= next_flag_c;
      flag_o <= next_flag_o;
    end
  end

  property p_priv_block;
    @(posedge clock) disable iff (!resetn)
      (ready && instr_valid && in_rw && !priv_allowed) |=> (priv_violation && done && ready);
  endproperty
  a_priv_block: assert property (p_priv_block)
    else $error("unprivileged access not refused");

  property p_read_lands_in_a;
    @(posedge clock) disable iff (!resetn)
      (ready && instr_valid && ilrs_is_read(instr) && priv_allowed)
        |=> (mem_we && mem_waddr == ilrs_idx($past(current_level), ILRS_SEL_A)) ##1 done;
  endproperty
  a_read_lands_in_a: assert property (p_read_lands_in_a)
    else $error("read not written to A");

  property p_status_read;
    @(posedge clock) disable iff (!resetn)
      (state == st_exec && ilrs_is_read(ir) && ir_sel == ILRS_SEL_STATUS)
        |-> (mem_wdata[15:8] == 8'h00 && !mem_wdata[0] && mem_wdata[7:1] == rdata_a[7:1]);
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status read badly placed");

  property p_write_target;
    @(posedge clock) disable iff (!resetn)
      (state == st_exec && ilrs_is_write(ir) && !own_pc)
        |-> (mem_we && mem_waddr == {ir_lvl, ir_sel} && $past(raddr_a) == {cur, ILRS_SEL_A});
  endproperty
  a_write_target: assert property (p_write_target)
    else $error("write went to wrong place");

  property p_own_pc;
    @(posedge clock) disable iff (!resetn)
      (state == st_exec && ilrs_is_write(ir) && own_pc) |-> !mem_we ##1 (done && ready);
  endproperty
  a_own_pc: assert property (p_own_pc) else $error("own counter was written");

  property p_status_write;
    @(posedge clock) disable iff (!resetn)
      (state == st_exec && ilrs_is_write(ir) && ir_sel == ILRS_SEL_STATUS)
        |-> (mem_wdata == (rdata_a & ILRS_STS_MASK));
  endproperty
  a_status_write: assert property (p_status_write)
    else $error("status write not bits 1-7");

  property p_extended_group;
    @(posedge clock) disable iff (!resetn)
      (ready && instr_valid && ilrs_is_skipgrp(instr) &&
       instr[ILRS_GRP_LSB +: ILRS_GRP_W] != ILRS_GRP_SKIP)
        |=> (extended_group && done && ready && !skip_taken);
  endproperty
  a_extended_group: assert property (p_extended_group)
    else $error("extended word taken as skip");

  property p_equal_skips;
    @(posedge clock) disable iff (!resetn)
      (state == st_exec && ilrs_is_skipgrp(ir) && ir_cond == ILRS_C_EQ && opd_d == opd_s)
        |=> (state == st_bump) ##1 (skip_taken && flag_z);
  endproperty
  a_equal_skips: assert property (p_equal_skips)
    else $error("equal compare did not skip");

  property p_no_skip;
    @(posedge clock) disable iff (!resetn)
      (state == st_exec && ilrs_is_skipgrp(ir) && !cond_hit) |=> (done && !skip_taken && ready);
  endproperty
  a_no_skip: assert property (p_no_skip) else $error("skip taken on false condition");
endmodule // ilrs_core

// ### dv/ilrs_core_tb.sv
// self-checking bench for the inter-level register and skip executor
`timescale 1ns/1ps
module ilrs_core_tb;
  import ilrs_pkg::*;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic [15:0] instr = 16'h0000;
  logic instr_valid = 1'b0;
  logic [3:0] current_level = 4'h0;
  logic priv_allowed = 1'b1;
  logic ready, done, priv_violation, skip_taken, extended_group;
  logic flag_s, flag_z, flag_c, flag_o;
  logic host_we = 1'b0;
  logic [3:0] host_level = 4'h0;
  logic [2:0] host_sel = 3'h0;
  logic [15:0] host_wdata = 16'h0000;
  logic [3:0] host_rd_level = 4'h0;
  logic [2:0] host_rd_sel = 3'h0;
  logic [15:0] host_rdata;
  logic got_pv, got_sk, got_eg;
  logic [15:0] v;
  int errors = 0;
  int num_checks = 0;

  always #12.5 clock = ~clock;

  ilrs_core dut (
    .clock(clock), .resetn(resetn), .instr(instr), .instr_valid(instr_valid),
    .current_level(current_level), .priv_allowed(priv_allowed), .ready(ready),
    .done(done), .priv_violation(priv_violation), .skip_taken(skip_taken),
    .extended_group(extended_group), .flag_s(flag_s), .flag_z(flag_z), .flag_c(flag_c),
    .flag_o(flag_o), .host_we(host_we), .host_level(host_level), .host_sel(host_sel),
    .host_wdata(host_wdata), .host_rd_level(host_rd_level), .host_rd_sel(host_rd_sel),
    .host_rdata(host_rdata)
  );

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // outside writes only land while idle, so these run between instructions
  task automatic wr(input logic [3:0] lvl, input logic [2:0] sel, input logic [15:0] d);
    @(negedge clock);
    host_we = 1'b1;
    host_level = lvl;
    host_sel = sel;
    host_wdata = d;
    @(negedge clock);
    host_we = 1'b0;
  endtask

  task automatic rd(input logic [3:0] lvl, input logic [2:0] sel, output logic [15:0] d);
    @(negedge clock);
    host_rd_level = lvl;
    host_rd_sel = sel;
    @(negedge clock);
    d = host_rdata;
  endtask

  task automatic exec(input logic [15:0] w, input logic [3:0] lvl, input logic pa);
    int i;
    @(negedge clock);
    instr = w;
    current_level = lvl;
    priv_allowed = pa;
    instr_valid = 1'b1;
    @(negedge clock);
    instr_valid = 1'b0;
    for (i = 0; i < 8; i++) begin
      if (done === 1'b1) break;
      @(negedge clock);
    end
    check("done", {15'h0000, done}, 16'h0001);
    got_pv = priv_violation;
    got_sk = skip_taken;
    got_eg = extended_group;
  endtask

  function automatic logic [15:0] rw_word(input logic [15:0] op, input logic [3:0] l,
                                          input logic [2:0] s);
    return op | {9'h000, l, s};
  endfunction

  // expected {sign, zero, carry, overflow} of destination minus source; carry means no borrow
  function automatic logic [3:0] exp_flags(input logic [15:0] d, input logic [15:0] s);
    logic [16:0] df;
    df = {1'b0, d} - {1'b0, s};
    return {df[15], df[15:0] == 16'h0000, !df[16], (d[15] != s[15]) && (df[15] != d[15])};
  endfunction

  function automatic logic exp_cond(input logic [2:0] cd, input logic [3:0] f);
    case (cd)
      3'h0: return f[2];
      3'h1: return !f[3];
      3'h2: return !(f[3] ^ f[0]);
      3'h3: return f[1];
      3'h4: return !f[2];
      3'h5: return f[3];
      3'h6: return f[3] ^ f[0];
      default: return !f[1];
    endcase
  endfunction

  task automatic t_levels();
    for (int l = 0; l < 16; l++) wr(l[3:0], 3'h3, 16'h1000 + 16'(l));
    for (int l = 0; l < 16; l++) begin
      exec(rw_word(ILRS_OP_READ, l[3:0], 3'h3), 4'h5, 1'b1);
      rd(4'h5, ILRS_SEL_A, v);
      check("read A", v, 16'h1000 + 16'(l));
    end
  endtask

  task automatic t_write();
    wr(4'h2, ILRS_SEL_A, 16'hbeef);
    exec(rw_word(ILRS_OP_WRITE, 4'h9, 3'h6), 4'h2, 1'b1);
    exec(rw_word(ILRS_OP_WRITE, 4'h2, 3'h4), 4'h2, 1'b1);
    rd(4'h9, 3'h6, v);
    check("write other", v, 16'hbeef);
    rd(4'h2, 3'h4, v);
    check("write own", v, 16'hbeef);
  endtask

  task automatic t_status();
    logic [15:0] a[2] = '{16'hffff, 16'h0055};
    for (int i = 0; i < 2; i++) begin
      wr(4'h2, ILRS_SEL_A, a[i]);
      exec(rw_word(ILRS_OP_WRITE, 4'h9, ILRS_SEL_STATUS), 4'h2, 1'b1);
      wr(4'h2, ILRS_SEL_A, 16'h1234);
      exec(rw_word(ILRS_OP_READ, 4'h9, ILRS_SEL_STATUS), 4'h2, 1'b1);
      rd(4'h2, ILRS_SEL_A, v);
      check("status", v, a[i] & 16'h00fe);
    end
  endtask

  task automatic t_pc();
    wr(4'h3, ILRS_SEL_P, 16'h0100);
    wr(4'h3, ILRS_SEL_A, 16'h0777);
    exec(rw_word(ILRS_OP_WRITE, 4'h3, ILRS_SEL_P), 4'h3, 1'b1);
    rd(4'h3, ILRS_SEL_P, v);
    check("own P", v, 16'h0100);
    exec(rw_word(ILRS_OP_WRITE, 4'h4, ILRS_SEL_P), 4'h3, 1'b1);
    rd(4'h4, ILRS_SEL_P, v);
    check("other P", v, 16'h0777);
  endtask

  task automatic t_priv();
    wr(4'h1, ILRS_SEL_A, 16'h1111);
    wr(4'h7, 3'h3, 16'h2222);
    exec(rw_word(ILRS_OP_READ, 4'h7, 3'h3), 4'h1, 1'b0);
    check("read refused", {15'h0000, got_pv}, 16'h0001);
    rd(4'h1, ILRS_SEL_A, v);
    check("A kept", v, 16'h1111);
    exec(rw_word(ILRS_OP_WRITE, 4'h7, 3'h3), 4'h1, 1'b0);
    check("write refused", {15'h0000, got_pv}, 16'h0001);
    rd(4'h7, 3'h3, v);
    check("target kept", v, 16'h2222);
  endtask

  // pairs cover less, greater, equal and a signed overflow
  task automatic t_skip();
    logic [15:0] dv[4] = '{16'h0005, 16'h0007, 16'h0005, 16'h8000};
    logic [15:0] sv[4] = '{16'h0007, 16'h0005, 16'h0005, 16'h0001};
    logic [3:0] f;
    logic e;
    for (int p = 0; p < 4; p++) begin
      wr(4'h6, 3'h3, dv[p]);
      wr(4'h6, 3'h4, sv[p]);
      f = exp_flags(dv[p], sv[p]);
      for (int c = 0; c < 8; c++) begin
        wr(4'h6, ILRS_SEL_P, 16'h0040);
        exec(ILRS_OP_SKIP | {5'h00, c[2:0], 2'h0, 3'h4, 3'h3}, 4'h6, 1'b1);
        e = exp_cond(c[2:0], f);
        check("skip", {15'h0000, got_sk}, {15'h0000, e});
        check("flags", {12'h000, flag_s, flag_z, flag_c, flag_o}, {12'h000, f});
        rd(4'h6, ILRS_SEL_P, v);
        check("skip P", v, 16'h0040 + {15'h0000, e});
      end
    end
  endtask

  task automatic t_other_group();
    wr(4'h6, 3'h3, 16'h0005);
    wr(4'h6, 3'h4, 16'h0005);
    for (int g = 1; g < 4; g++) begin
      wr(4'h6, ILRS_SEL_P, 16'h0040);
      exec(ILRS_OP_SKIP | {8'h00, g[1:0], 3'h4, 3'h3}, 4'h6, 1'b1);
      check("extended group", {14'h0000, got_eg, got_sk}, 16'h0002);
      rd(4'h6, ILRS_SEL_P, v);
      check("extended P", v, 16'h0040);
    end
    // source code 0 compares against zero, and a skip needs no privilege
    wr(4'h6, ILRS_SEL_P, 16'h0040);
    exec(ILRS_OP_SKIP | {5'h00, 3'h4, 2'h0, 3'h0, 3'h3}, 4'h6, 1'b0);
    check("zero source", {14'h0000, got_pv, got_sk}, 16'h0001);
    rd(4'h6, ILRS_SEL_P, v);
    check("zero source P", v, 16'h0041);
  endtask

  initial begin
    repeat (6) @(negedge clock);
    resetn = 1'b1;
    t_levels();
    t_write();
    t_status();
    t_pc();
    t_priv();
    t_skip();
    t_other_group();
    finish_test();
  end

  // the whole run needs well under 2000 cycles
  initial begin
    #(25 * 20000);
    errors++;
    finish_test();
  end
endmodule // ilrs_core_tb
